/* hw/serv_view.sv */
// Contract
// [RULE1] Low views bits 31:0, high 63:32
// [RULE2] Address high at p15,0,c5,c4,7
// [RULE3] Control low at p15,0,c5,c4,1
// [RULE4] Control high at p15,0,c5,c4,5
// [RULE5] Feature low read-only at opcode2 0
// [RULE6] Feature high read-only at opcode2 4
// [RULE7] Lowest level access is undefined
// [RULE8] Out-of-range selector: configured fallback behaviour
// [RULE9] Hyp 64 error trap from NS kernel
// [RULE10] Hyp 64 c5 trap from NS kernel
// [RULE11] Hyp 32 either bit traps NS kernel
// [RULE12] Monitor 64 traps levels two and one
// [RULE13] Monitor 32 traps all but monitor mode
// [RULE14] Traps follow exception priority order
// [RULE15] One shared instance, no banking
// [RULE16] Absent extension makes access undefined
// [RULE17] Each view is 32 bits
// [RULE18] Selector bits 15:0 choose record
// [RULE19] Count holds top index plus one
// [RULE20] Write updates only addressed half
module serv_view #(
  parameter serv_pkg::serv_oor_t OOR_MODE = serv_pkg::SERV_OOR_RAZWI
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic acc_read,
  input wire logic [3:0] acc_cp,
  input wire logic [2:0] acc_opc1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_opc2,
  input wire logic [31:0] acc_wdata,
  input wire logic ext_present,
  input wire logic [1:0] cur_el,
  input wire logic non_secure,
  input wire logic monitor_mode,
  input wire logic hyp_present,
  input wire logic hyp_is_64,
  input wire logic mon_present,
  input wire logic mon_is_64,
  input wire logic hyp_error_trap_64,
  input wire logic hyp_c5_trap_64,
  input wire logic hyp_error_trap_32,
  input wire logic hyp_c5_trap_32,
  input wire logic monitor_error_trap_64,
  input wire logic monitor_error_trap_32,
  input wire logic [15:0] record_selector,
  input wire logic [15:0] record_count,
  output logic rec_wr,
  output logic [15:0] rec_index,
  output logic [63:0] rec_addr_wdata,
  output logic [63:0] rec_ctrl_wdata,
  output logic rec_addr_we,
  output logic rec_ctrl_we,
  input wire logic [63:0] record_addr,
  input wire logic [63:0] record_control_reg,
  input wire logic [63:0] record_feature_reg,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic resp_undef,
  output logic resp_hyp_trap,
  output logic resp_hyp_trap32,
  output logic resp_mon_trap,
  output logic resp_mon_trap32,
  output logic view_hit
);
  serv_pkg::serv_view_t view;
  serv_pkg::serv_res_t res;
  logic in_range;
  logic go;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic valid_reg;
  logic [4:0] flags_next;
  logic [4:0] flags_reg;
  localparam int LO_MSB_C = serv_pkg::LO_MSB;
  localparam int HI_LSB_C = serv_pkg::HI_LSB;

  serv_decode u_dec (
    .cp_num(acc_cp),
    .opc1(acc_opc1),
    .crn(acc_crn),
    .crm(acc_crm),
    .opc2(acc_opc2),
    .is_read(acc_read),
    .view(view)
  );

  serv_trap u_trap (
    .ext_present(ext_present),
    .cur_el(cur_el),
    .non_secure(non_secure),
    .monitor_mode(monitor_mode),
    .hyp_present(hyp_present),
    .hyp_is_64(hyp_is_64),
    .mon_present(mon_present),
    .mon_is_64(mon_is_64),
    .hyp_error_trap_64(hyp_error_trap_64),
    .hyp_c5_trap_64(hyp_c5_trap_64),
    .hyp_error_trap_32(hyp_error_trap_32),
    .hyp_c5_trap_32(hyp_c5_trap_32),
    .monitor_error_trap_64(monitor_error_trap_64),
    .monitor_error_trap_32(monitor_error_trap_32),
    .res(res)
  );

  assign view_hit = acc_valid && view != serv_pkg::SERV_NONE;
  // [RULE18] [RULE19] Count of zero leaves nothing in range
  assign in_range = record_selector < record_count;
  // [RULE15] No security banking: selector used as is
  assign rec_index = record_selector;

  // [RULE8] Unknown record mode still forwards
  assign go = view_hit && res == serv_pkg::SERV_RES_OK
    && (in_range || OOR_MODE == serv_pkg::SERV_OOR_UNKNOWN);

  // [RULE20] Merge write into addressed half
  always_comb
  begin
    rec_wr = go && !acc_read;
    rec_addr_we = rec_wr && view == serv_pkg::SERV_ADDR_HI;
    rec_ctrl_we = rec_wr && (view == serv_pkg::SERV_CTRL_LO
      || view == serv_pkg::SERV_CTRL_HI);
    rec_addr_wdata = {acc_wdata, record_addr[LO_MSB_C:0]};
    rec_ctrl_wdata = record_control_reg;
    if (view == serv_pkg::SERV_CTRL_LO)
      rec_ctrl_wdata = {record_control_reg[63:HI_LSB_C], acc_wdata};
    else
      rec_ctrl_wdata = {acc_wdata, record_control_reg[LO_MSB_C:0]};
  end

  // Halves must meet at bit 32, or merges corrupt the record
  if (LO_MSB_C + 1 != HI_LSB_C || HI_LSB_C != 32)
  begin : g_bad_split
    $error("record halves must split at bit 32");
  end

  // [RULE1] [RULE17] Select 32-bit half
  always_comb
  begin
    rdata_next = serv_pkg::READ_ZERO;
    if (go && acc_read)
    begin
      case (view)
        serv_pkg::SERV_ADDR_HI: rdata_next = record_addr[63:HI_LSB_C];
        serv_pkg::SERV_CTRL_LO: rdata_next = record_control_reg[LO_MSB_C:0];
        serv_pkg::SERV_CTRL_HI: rdata_next = record_control_reg[63:HI_LSB_C];
        serv_pkg::SERV_FEAT_LO: rdata_next = record_feature_reg[LO_MSB_C:0];
        serv_pkg::SERV_FEAT_HI: rdata_next = record_feature_reg[63:HI_LSB_C];
        default: rdata_next = serv_pkg::READ_ZERO;
      endcase
    end
    flags_next = 5'h00;
    if (view_hit)
    begin
      case (res)
        serv_pkg::SERV_RES_UNDEF: flags_next = 5'h01;
        serv_pkg::SERV_RES_HYP64: flags_next = 5'h02;
        serv_pkg::SERV_RES_HYP32: flags_next = 5'h04;
        serv_pkg::SERV_RES_MON64: flags_next = 5'h08;
        serv_pkg::SERV_RES_MON32: flags_next = 5'h10;
        default:
        begin
          // [RULE8] Out-of-range undefined option
          if (!in_range && OOR_MODE == serv_pkg::SERV_OOR_UNDEF)
            flags_next = 5'h01;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
      flags_reg <= 5'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
      valid_reg <= view_hit;
      flags_reg <= flags_next;
    end
  end

  assign resp_valid = valid_reg;
  assign resp_rdata = rdata_reg;
  assign resp_undef = flags_reg[0];
  assign resp_hyp_trap = flags_reg[1];
  assign resp_hyp_trap32 = flags_reg[2];
  assign resp_mon_trap = flags_reg[3];
  assign resp_mon_trap32 = flags_reg[4];

  // [RULE7] user access answered undefined
  chk_user_undef: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    (view_hit && ext_present && cur_el == serv_pkg::EL_USER) |=> resp_undef && resp_valid)
    else $error("user access not undefined");

  // [RULE16] absent extension
  chk_absent_undef: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
    (view_hit && !ext_present) |=> resp_undef && !resp_hyp_trap && !resp_mon_trap)
    else $error("absent extension not undefined");

  // [RULE9] hyp 64 trap
  chk_hyp64_trap: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    (view_hit && ext_present && hyp_present && hyp_is_64 && non_secure
     && cur_el == serv_pkg::EL_KERNEL && hyp_error_trap_64) |=> resp_hyp_trap)
    else $error("hyp 64 trap missing");

  // [RULE11] hyp 32 trap
  chk_hyp32_trap: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    (view_hit && ext_present && hyp_present && !hyp_is_64 && non_secure
     && cur_el == serv_pkg::EL_KERNEL && hyp_c5_trap_32) |=> resp_hyp_trap32)
    else $error("hyp 32 trap missing");

  // [RULE12] monitor 64 trap at level two
  chk_mon64_trap: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
    (view_hit && ext_present && mon_present && mon_is_64 && monitor_error_trap_64
     && cur_el == serv_pkg::EL_HYP) |=> resp_mon_trap)
    else $error("monitor 64 trap missing");

  // [RULE13] monitor mode exempt
  chk_mon32_exempt: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    (view_hit && monitor_mode && !mon_is_64) |=> !resp_mon_trap32)
    else $error("monitor mode trapped");

  // [RULE20] other half preserved
  chk_half_keep: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
    rec_ctrl_we && view == serv_pkg::SERV_CTRL_LO
    |-> rec_ctrl_wdata[63:32] == record_control_reg[63:32])
    else $error("control high half disturbed");

  // [RULE5] feature never written
  chk_feat_ro: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (acc_valid && !acc_read && acc_opc2 == serv_pkg::OPC2_FEAT_LO) |-> !rec_wr)
    else $error("feature view written");

  // [RULE1] control high read data
  chk_ctrl_hi_rd: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    (go && acc_read && view == serv_pkg::SERV_CTRL_HI)
    |=> resp_rdata == $past(record_control_reg[63:32]))
    else $error("control high read wrong");

  // [RULE1] address high read data
  chk_addr_hi_rd: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    (go && acc_read && view == serv_pkg::SERV_ADDR_HI)
    |=> resp_rdata == $past(record_addr[63:32]))
    else $error("address high read wrong");

  // [RULE2] every hit answered once
  chk_hit_answered: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    resp_valid == $past(view_hit))
    else $error("response does not follow hit");

  // [RULE6] feature high never written
  chk_feat_hi_ro: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    (acc_valid && !acc_read && acc_opc2 == serv_pkg::OPC2_FEAT_HI) |-> !rec_wr)
    else $error("feature high view written");

  // [RULE7] user level never forwarded
  chk_user_no_fwd: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    (view_hit && cur_el == serv_pkg::EL_USER) |-> !rec_wr)
    else $error("user access forwarded");

  // [RULE8] out of range never written unless the out-of-range mode is unknown
  chk_oor_no_write: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    (view_hit && !in_range && OOR_MODE != serv_pkg::SERV_OOR_UNKNOWN) |-> !rec_wr)
    else $error("out of range record written");

  // [RULE10] hyp 64 c5 trap
  chk_hyp64_c5: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
    (view_hit && ext_present && hyp_present && hyp_is_64 && non_secure
     && cur_el == serv_pkg::EL_KERNEL && hyp_c5_trap_64) |=> resp_hyp_trap)
    else $error("hyp 64 c5 trap missing");

  // [RULE11] hyp 32 error trap
  chk_hyp32_err: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    (view_hit && ext_present && hyp_present && !hyp_is_64 && non_secure
     && cur_el == serv_pkg::EL_KERNEL && hyp_error_trap_32) |=> resp_hyp_trap32)
    else $error("hyp 32 error trap missing");

  // [RULE12] monitor 64 trap at level one
  chk_mon64_kernel: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
    (view_hit && ext_present && mon_present && mon_is_64 && monitor_error_trap_64
     && cur_el == serv_pkg::EL_KERNEL && !non_secure) |=> resp_mon_trap)
    else $error("monitor 64 trap missing at level one");

  // [RULE13] monitor 32 trap outside monitor mode
  chk_mon32_trap: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    (view_hit && ext_present && cur_el != serv_pkg::EL_USER && !hyp_present
     && mon_present && !mon_is_64 && monitor_error_trap_32 && !monitor_mode)
    |=> resp_mon_trap32)
    else $error("monitor 32 trap missing");

  // [RULE14] one outcome per access
  chk_one_outcome: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    $onehot0({resp_undef, resp_hyp_trap, resp_hyp_trap32, resp_mon_trap, resp_mon_trap32}))
    else $error("more than one trap flag");

  // [RULE19] zero count reads zero unless the out-of-range mode is unknown
  chk_zero_count: assert property (@(posedge clk) disable iff (!rst_n) // [RULE19]
    (view_hit && acc_read && record_count == 16'h0000
     && OOR_MODE != serv_pkg::SERV_OOR_UNKNOWN) |=> resp_rdata == serv_pkg::READ_ZERO)
    else $error("zero count read not zero");

  // [RULE20] address low half preserved
  chk_addr_keep: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
    rec_addr_we |-> rec_addr_wdata[31:0] == record_addr[31:0])
    else $error("address low half disturbed");

  // [RULE20] control low half preserved
  chk_ctrl_lo_keep: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
    rec_ctrl_we && view == serv_pkg::SERV_CTRL_HI
    |-> rec_ctrl_wdata[31:0] == record_control_reg[31:0])
    else $error("control low half disturbed");
endmodule // serv_view

/* hw/serv_pkg.sv */
package serv_pkg;
  localparam logic [3:0] CP_NUM = 4'hf;
  localparam logic [2:0] OPC1_VIEW = 3'h0;
  localparam logic [3:0] CRN_VIEW = 4'h5;
  localparam logic [3:0] CRM_VIEW = 4'h4;
  localparam logic [2:0] OPC2_FEAT_LO = 3'h0;
  localparam logic [2:0] OPC2_CTRL_LO = 3'h1;
  localparam logic [2:0] OPC2_FEAT_HI = 3'h4;
  localparam logic [2:0] OPC2_CTRL_HI = 3'h5;
  localparam logic [2:0] OPC2_ADDR_HI = 3'h7;
  localparam int SEL_W = 16;
  localparam int LO_MSB = 31;
  localparam int HI_LSB = 32;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [1:0] EL_USER = 2'h0;
  localparam logic [1:0] EL_KERNEL = 2'h1;
  localparam logic [1:0] EL_HYP = 2'h2;
  typedef enum logic [2:0] {SERV_NONE, SERV_ADDR_HI, SERV_CTRL_LO, SERV_CTRL_HI,
    SERV_FEAT_LO, SERV_FEAT_HI} serv_view_t;
  typedef enum logic [1:0] {SERV_OOR_UNKNOWN, SERV_OOR_RAZWI, SERV_OOR_NOP,
    SERV_OOR_UNDEF} serv_oor_t;
  typedef enum logic [2:0] {SERV_RES_OK, SERV_RES_UNDEF, SERV_RES_HYP64,
    SERV_RES_HYP32, SERV_RES_MON64, SERV_RES_MON32} serv_res_t;
endpackage

/* hw/serv_decode.sv */
module serv_decode (
  input wire logic [3:0] cp_num,
  input wire logic [2:0] opc1,
  input wire logic [3:0] crn,
  input wire logic [3:0] crm,
  input wire logic [2:0] opc2,
  input wire logic is_read,
  output serv_pkg::serv_view_t view
);
  always_comb
  begin
    view = serv_pkg::SERV_NONE;
    if (cp_num == serv_pkg::CP_NUM && opc1 == serv_pkg::OPC1_VIEW
        && crn == serv_pkg::CRN_VIEW && crm == serv_pkg::CRM_VIEW)
    begin
      // [RULE2] address high view
      if (opc2 == serv_pkg::OPC2_ADDR_HI)
        view = serv_pkg::SERV_ADDR_HI;
      // [RULE3] control low view
      else if (opc2 == serv_pkg::OPC2_CTRL_LO)
        view = serv_pkg::SERV_CTRL_LO;
      // [RULE4] control high view
      else if (opc2 == serv_pkg::OPC2_CTRL_HI)
        view = serv_pkg::SERV_CTRL_HI;
      // [RULE5] feature low, reads only
      else if (opc2 == serv_pkg::OPC2_FEAT_LO && is_read)
        view = serv_pkg::SERV_FEAT_LO;
      // [RULE6] feature high, reads only
      else if (opc2 == serv_pkg::OPC2_FEAT_HI && is_read)
        view = serv_pkg::SERV_FEAT_HI;
    end
  end
endmodule // serv_decode

/* hw/serv_trap.sv */
module serv_trap (
  input wire logic ext_present,
  input wire logic [1:0] cur_el,
  input wire logic non_secure,
  input wire logic monitor_mode,
  input wire logic hyp_present,
  input wire logic hyp_is_64,
  input wire logic mon_present,
  input wire logic mon_is_64,
  input wire logic hyp_error_trap_64,
  input wire logic hyp_c5_trap_64,
  input wire logic hyp_error_trap_32,
  input wire logic hyp_c5_trap_32,
  input wire logic monitor_error_trap_64,
  input wire logic monitor_error_trap_32,
  output serv_pkg::serv_res_t res
);
  logic ns_kernel;
  assign ns_kernel = non_secure && cur_el == serv_pkg::EL_KERNEL;
  always_comb
  begin
    res = serv_pkg::SERV_RES_OK;
    // [RULE14] Highest priority first
    // [RULE16] absent extension undefined
    if (!ext_present)
      res = serv_pkg::SERV_RES_UNDEF;
    // [RULE7] user level undefined
    else if (cur_el == serv_pkg::EL_USER)
      res = serv_pkg::SERV_RES_UNDEF;
    // [RULE9] [RULE10] hypervisor 64 trap
    else if (hyp_present && hyp_is_64 && ns_kernel
             && (hyp_error_trap_64 || hyp_c5_trap_64))
      res = serv_pkg::SERV_RES_HYP64;
    // [RULE11] hypervisor 32 trap
    else if (hyp_present && !hyp_is_64 && ns_kernel
             && (hyp_error_trap_32 || hyp_c5_trap_32))
      res = serv_pkg::SERV_RES_HYP32;
    // [RULE12] monitor 64 trap
    else if (mon_present && mon_is_64 && monitor_error_trap_64
             && (cur_el == serv_pkg::EL_KERNEL || cur_el == serv_pkg::EL_HYP))
      res = serv_pkg::SERV_RES_MON64;
    // [RULE13] monitor 32 trap
    else if (mon_present && !mon_is_64 && monitor_error_trap_32 && !monitor_mode)
      res = serv_pkg::SERV_RES_MON32;
  end
endmodule // serv_trap

/* test/serv_rec_model.sv */
module serv_rec_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] rec_index,
  input wire logic rec_addr_we,
  input wire logic rec_ctrl_we,
  input wire logic [63:0] rec_addr_wdata,
  input wire logic [63:0] rec_ctrl_wdata,
  output logic [63:0] record_addr,
  output logic [63:0] record_control_reg,
  output logic [63:0] record_feature_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only four records held; the bench keeps the selector below four when forwarding
  logic [63:0] addr_reg [4];
  logic [63:0] ctrl_reg [4];
  assign record_addr = addr_reg[rec_index[1:0]];
  assign record_control_reg = ctrl_reg[rec_index[1:0]];
  assign record_feature_reg = {16'hfe00, rec_index, 16'hfe01, rec_index};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        addr_reg[i] <= {32'ha0a0_0000, 32'h0a0a_0000};
        ctrl_reg[i] <= {32'hc0c0_0000, 32'h0c0c_0000};
      end
    end
    else
    begin
      if (rec_addr_we)
        addr_reg[rec_index[1:0]] <= rec_addr_wdata;
      if (rec_ctrl_we)
        ctrl_reg[rec_index[1:0]] <= rec_ctrl_wdata;
    end
  end
endmodule // serv_rec_model

/* test/selected_error_record_view_test.sv */
`define CHK(nm, exp, got) \
  begin \
    compares += 1; \
    if ((got) !== (exp)) \
    begin \
      errors += 1; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module selected_error_record_view_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, acc_valid, acc_read, ext_present, non_secure, monitor_mode;
  logic [2:0] acc_opc2;
  logic [31:0] acc_wdata, resp_rdata, rdat;
  logic [1:0] cur_el;
  logic hyp_present, hyp_is_64, mon_present, mon_is_64, rv, we_seen;
  logic hyp_error_trap_64, hyp_c5_trap_64, hyp_error_trap_32, hyp_c5_trap_32;
  logic monitor_error_trap_64, monitor_error_trap_32;
  logic [15:0] record_selector, record_count, rec_index;
  logic rec_wr, rec_addr_we, rec_ctrl_we, resp_valid, resp_undef, resp_hyp_trap;
  logic resp_hyp_trap32, resp_mon_trap, resp_mon_trap32;
  logic [63:0] rec_addr_wdata, rec_ctrl_wdata, record_addr, record_control_reg;
  logic [63:0] record_feature_reg;
  logic [4:0] fl;
  logic [3:0] acc_cp, acc_crn, acc_crm;
  logic [2:0] acc_opc1;
  logic view_hit, vh, oor_valid, oor_undef;
  logic [1:0] oor_fl;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  serv_view uut (.clk(clk), .rst_n(rst_n), .acc_valid(acc_valid), .acc_read(acc_read),
    .acc_cp(acc_cp), .acc_opc1(acc_opc1), .acc_crn(acc_crn),
    .acc_crm(acc_crm), .acc_opc2(acc_opc2), .acc_wdata(acc_wdata),
    .ext_present(ext_present), .cur_el(cur_el), .non_secure(non_secure),
    .monitor_mode(monitor_mode), .hyp_present(hyp_present), .hyp_is_64(hyp_is_64),
    .mon_present(mon_present), .mon_is_64(mon_is_64), .hyp_error_trap_64(hyp_error_trap_64),
    .hyp_c5_trap_64(hyp_c5_trap_64), .hyp_error_trap_32(hyp_error_trap_32),
    .hyp_c5_trap_32(hyp_c5_trap_32), .monitor_error_trap_64(monitor_error_trap_64),
    .monitor_error_trap_32(monitor_error_trap_32), .record_selector(record_selector),
    .record_count(record_count), .rec_wr(rec_wr), .rec_index(rec_index),
    .rec_addr_wdata(rec_addr_wdata), .rec_ctrl_wdata(rec_ctrl_wdata),
    .rec_addr_we(rec_addr_we), .rec_ctrl_we(rec_ctrl_we), .record_addr(record_addr),
    .record_control_reg(record_control_reg), .record_feature_reg(record_feature_reg),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_undef(resp_undef),
    .resp_hyp_trap(resp_hyp_trap), .resp_hyp_trap32(resp_hyp_trap32),
    .resp_mon_trap(resp_mon_trap), .resp_mon_trap32(resp_mon_trap32), .view_hit(view_hit));
  // Second copy shows the undefined option for out-of-range selectors
  serv_view #(.OOR_MODE(serv_pkg::SERV_OOR_UNDEF)) uut_oor (.clk(clk), .rst_n(rst_n),
    .acc_valid(acc_valid), .acc_read(acc_read), .acc_cp(acc_cp), .acc_opc1(acc_opc1),
    .acc_crn(acc_crn), .acc_crm(acc_crm), .acc_opc2(acc_opc2), .acc_wdata(acc_wdata),
    .ext_present(ext_present), .cur_el(cur_el), .non_secure(non_secure),
    .monitor_mode(monitor_mode), .hyp_present(hyp_present), .hyp_is_64(hyp_is_64),
    .mon_present(mon_present), .mon_is_64(mon_is_64), .hyp_error_trap_64(hyp_error_trap_64),
    .hyp_c5_trap_64(hyp_c5_trap_64), .hyp_error_trap_32(hyp_error_trap_32),
    .hyp_c5_trap_32(hyp_c5_trap_32), .monitor_error_trap_64(monitor_error_trap_64),
    .monitor_error_trap_32(monitor_error_trap_32), .record_selector(record_selector),
    .record_count(record_count), .rec_wr(), .rec_index(), .rec_addr_wdata(),
    .rec_ctrl_wdata(), .rec_addr_we(), .rec_ctrl_we(), .record_addr(record_addr),
    .record_control_reg(record_control_reg), .record_feature_reg(record_feature_reg),
    .resp_valid(oor_valid), .resp_rdata(), .resp_undef(oor_undef), .resp_hyp_trap(),
    .resp_hyp_trap32(), .resp_mon_trap(), .resp_mon_trap32(), .view_hit());
  serv_rec_model rec (.clk(clk), .rst_n(rst_n), .rec_index(rec_index),
    .rec_addr_we(rec_addr_we), .rec_ctrl_we(rec_ctrl_we), .rec_addr_wdata(rec_addr_wdata),
    .rec_ctrl_wdata(rec_ctrl_wdata), .record_addr(record_addr),
    .record_control_reg(record_control_reg), .record_feature_reg(record_feature_reg));
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the roughly 70 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles += 1;
    if (cycles == 2000)
    begin
      errors += 1;
      end_sim;
    end
  end
  // Entered and left 1 ns after a rising edge; an idle cycle follows each access
  task automatic acc(input logic rd, input logic [2:0] o2, input logic [31:0] wd);
    acc_valid = 1'h1;
    acc_read = rd;
    acc_opc2 = o2;
    acc_wdata = wd;
    @(posedge clk);
    we_seen = rec_wr | rec_addr_we | rec_ctrl_we;
    vh = view_hit;
    #1 acc_valid = 1'h0;
    rv = resp_valid;
    rdat = resp_rdata;
    fl = {resp_undef, resp_hyp_trap, resp_hyp_trap32, resp_mon_trap, resp_mon_trap32};
    oor_fl = {oor_valid, oor_undef};
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] o2, input logic [31:0] ed, input logic [4:0] ef);
    acc(1'h1, o2, 32'h0000_0000);
    `CHK("resp_valid", 1'h1, rv)
    `CHK("resp_rdata", ed, rdat)
    `CHK("resp flags", ef, fl)
  endtask
  // Configuration only, no access, so it may run inside reset
  task automatic cfg(input logic [4:0] cf, input logic [5:0] tr, input logic [1:0] el,
    input logic ns, input logic mm);
    {ext_present, hyp_present, hyp_is_64, mon_present, mon_is_64} = cf;
    {hyp_error_trap_64, hyp_c5_trap_64, hyp_error_trap_32, hyp_c5_trap_32,
      monitor_error_trap_64, monitor_error_trap_32} = tr;
    cur_el = el;
    non_secure = ns;
    monitor_mode = mm;
  endtask
  task automatic trap(input logic [4:0] cf, input logic [5:0] tr, input logic [1:0] el,
    input logic ns, input logic mm, input logic [4:0] ef);
    cfg(cf, tr, el, ns, mm);
    rd(serv_pkg::OPC2_FEAT_LO, ef == 5'h00 ? 32'hfe01_0000 : serv_pkg::READ_ZERO, ef);
  endtask
  initial
  begin
    rst_n = 1'h0;
    {acc_valid, acc_read, acc_opc2, acc_wdata} = '0;
    {acc_cp, acc_opc1, acc_crn, acc_crm} = {serv_pkg::CP_NUM, serv_pkg::OPC1_VIEW,
      serv_pkg::CRN_VIEW, serv_pkg::CRM_VIEW};
    cfg(5'h10, 6'h00, 2'h1, 1'h1, 1'h0);
    record_selector = 16'h0000;
    record_count = 16'h0004;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    acc(1'h0, serv_pkg::OPC2_CTRL_LO, 32'h1234_5678);
    `CHK("control low strobe", 1'h1, we_seen)
    non_secure = 1'h0;
    rd(serv_pkg::OPC2_CTRL_LO, 32'h1234_5678, 5'h00);
    `CHK("undef option in range", 2'h2, oor_fl)
    rd(serv_pkg::OPC2_CTRL_HI, 32'hc0c0_0000, 5'h00);
    acc(1'h0, serv_pkg::OPC2_CTRL_HI, 32'h9abc_def0);
    rd(serv_pkg::OPC2_CTRL_LO, 32'h1234_5678, 5'h00);
    rd(serv_pkg::OPC2_CTRL_HI, 32'h9abc_def0, 5'h00);
    acc(1'h0, serv_pkg::OPC2_ADDR_HI, 32'h5555_aaaa);
    `CHK("address high strobe", 1'h1, we_seen)
    rd(serv_pkg::OPC2_ADDR_HI, 32'h5555_aaaa, 5'h00);
    acc(1'h1, 3'h3, 32'h0000_0000);
    `CHK("other encoding", 1'h0, rv)
    `CHK("other encoding hit", 1'h0, vh)
    acc_cp = 4'he;
    acc(1'h1, serv_pkg::OPC2_CTRL_LO, 32'h0000_0000);
    `CHK("other coprocessor", 1'h0, rv | vh)
    acc_cp = serv_pkg::CP_NUM;
    acc_crm = 4'h3;
    acc(1'h1, serv_pkg::OPC2_CTRL_LO, 32'h0000_0000);
    `CHK("other secondary register", 1'h0, rv | vh)
    acc_crm = serv_pkg::CRM_VIEW;
    record_selector = 16'h0002;
    rd(serv_pkg::OPC2_ADDR_HI, 32'ha0a0_0000, 5'h00);
    rd(serv_pkg::OPC2_FEAT_LO, 32'hfe01_0002, 5'h00);
    rd(serv_pkg::OPC2_FEAT_HI, 32'hfe00_0002, 5'h00);
    acc(1'h0, serv_pkg::OPC2_FEAT_LO, 32'hffff_ffff);
    `CHK("feature low write", 1'h0, rv | we_seen)
    acc(1'h0, serv_pkg::OPC2_FEAT_HI, 32'hffff_ffff);
    `CHK("feature high write", 1'h0, rv | we_seen)
    record_count = 16'h0002;
    rd(serv_pkg::OPC2_CTRL_LO, serv_pkg::READ_ZERO, 5'h00);
    `CHK("undefined option", 2'h3, oor_fl)
    acc(1'h0, serv_pkg::OPC2_CTRL_LO, 32'hffff_ffff);
    `CHK("out of range write", 1'h0, we_seen)
    record_count = 16'h0000;
    record_selector = 16'h0000;
    rd(serv_pkg::OPC2_ADDR_HI, serv_pkg::READ_ZERO, 5'h00);
    record_count = 16'h0004;
    rd(serv_pkg::OPC2_ADDR_HI, 32'h5555_aaaa, 5'h00);
    trap(5'h1c, 6'h20, 2'h1, 1'h1, 1'h0, 5'h08);
    trap(5'h1c, 6'h20, 2'h1, 1'h0, 1'h0, 5'h00);
    trap(5'h1c, 6'h10, 2'h1, 1'h1, 1'h0, 5'h08);
    trap(5'h18, 6'h08, 2'h1, 1'h1, 1'h0, 5'h04);
    trap(5'h18, 6'h04, 2'h1, 1'h1, 1'h0, 5'h04);
    trap(5'h13, 6'h02, 2'h2, 1'h1, 1'h0, 5'h02);
    trap(5'h13, 6'h02, 2'h1, 1'h0, 1'h0, 5'h02);
    trap(5'h13, 6'h02, 2'h3, 1'h0, 1'h0, 5'h00);
    trap(5'h12, 6'h01, 2'h3, 1'h0, 1'h0, 5'h01);
    trap(5'h12, 6'h01, 2'h3, 1'h0, 1'h1, 5'h00);
    trap(5'h1f, 6'h22, 2'h1, 1'h1, 1'h0, 5'h08);
    trap(5'h1c, 6'h20, 2'h0, 1'h1, 1'h0, 5'h10);
    trap(5'h00, 6'h00, 2'h1, 1'h1, 1'h0, 5'h10);
    end_sim;
  end
endmodule // selected_error_record_view_test
